// [reset_seq_pkg.sv]
/*
 * reset_seq_pkg: timing constants and state codes for the display
 * hardware reset sequencer. Assumes a 40 MHz core clock.
 */
package reset_seq_pkg;

    localparam int CLK_PERIOD_NS = 25;

    // spike filter thresholds in microseconds
    localparam int REJECT_US = 5;
    localparam int ACCEPT_US = 9;
    // least reject window rounds down, accept point rounds up
    localparam int REJECT_CYCLES = (REJECT_US * 1000) / CLK_PERIOD_NS;
    localparam int ACCEPT_CYCLES = (ACCEPT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // recovery, load and blanking times in milliseconds
    localparam int RECOVER_SLEEP_MS = 5;
    localparam int RECOVER_AWAKE_MS = 120;
    localparam int NVM_LOAD_MS = 5;
    localparam int BLANK_MAX_MS = 120;
    // longest times round down
    localparam int RECOVER_SLEEP_CYCLES = (RECOVER_SLEEP_MS * 1000000) / CLK_PERIOD_NS;
    localparam int RECOVER_AWAKE_CYCLES = (RECOVER_AWAKE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int NVM_LOAD_CYCLES = (NVM_LOAD_MS * 1000000) / CLK_PERIOD_NS;
    localparam int BLANK_MAX_CYCLES = (BLANK_MAX_MS * 1000000) / CLK_PERIOD_NS;

    localparam int COUNT_W = 23;
    localparam int FILT_W = 10;

    // reset values of the stored settings
    localparam logic [7:0] COMMON_VOLTAGE_SETTING_RESET = 8'h00;

    typedef enum logic [4:0] {
        ST_RUN     = 5'b00001,
        ST_BLANK   = 5'b00010,
        ST_HOLD    = 5'b00100,
        ST_RECOVER = 5'b01000,
        ST_WAIT    = 5'b10000
    } seq_state_type;

endpackage

// [display_hw_reset_sequencer.sv]
/*
 * display_hw_reset_sequencer: filters the active-low hardware reset pin,
 * blanks the panel, reloads stored settings and times the recovery.
 * Assumes CORE_CLK runs free at 40 MHz and that the non-volatile store
 * answers a load request with a data-valid pulse.
 * The pin is the only input from outside the clock domain; the sleep
 * level, blanking done flag and store handshake come from logic on the
 * same clock and are used directly. The panel blanking engine and the
 * store itself sit outside this block.
 */
`timescale 1ns/1ps
module display_hw_reset_sequencer #(
    parameter int RECOVER_SLEEP_CNT = reset_seq_pkg::RECOVER_SLEEP_CYCLES,
    parameter int RECOVER_AWAKE_CNT = reset_seq_pkg::RECOVER_AWAKE_CYCLES,
    parameter int NVM_LOAD_CNT = reset_seq_pkg::NVM_LOAD_CYCLES,
    parameter int BLANK_MAX_CNT = reset_seq_pkg::BLANK_MAX_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic HW_RESET_PIN_N,
    input wire logic SLEEP_IN,
    input wire logic BLANK_DONE,
    input wire logic NVM_VALID,
    input wire logic [7:0] NVM_ID,
    input wire logic [7:0] NVM_COMMON_VOLTAGE_SETTING,
    output logic IN_RESET,
    output logic BLANK_DISPLAY,
    output logic LOAD_DEFAULTS,
    output logic NVM_LOAD_REQ,
    output logic [7:0] ID_BYTE,
    output logic [7:0] COMMON_VOLTAGE_SETTING,
    output logic CMD_READY,
    output logic WAKE_READY
);
    import reset_seq_pkg::*;

    // synchroniser stages and the settled pin level
    logic [2:0] pin_sync_q;
    logic pin_level_q;
    // spike filter: low time and high time in core cycles
    logic [FILT_W-1:0] low_cnt_q;
    logic [FILT_W-1:0] high_cnt_q;
    // filtered reset, the only form of the pin that the sequence looks at
    logic reset_req_q;
    // shared phase timer and the time since the last release
    logic [COUNT_W-1:0] tmr_q;
    logic [COUNT_W-1:0] since_rel_q;
    // settings taken from the store in this recovery
    logic loaded_q;
    seq_state_type state_q;

    // three-stage pin synchroniser; stage 0 feeds only stage 1
    // a level counts only once stages 1 and 2 agree, so a pin edge
    // caught mid-transition cannot reach the filter as a one-cycle blip
    // idle level is high so no false low follows a core reset
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            pin_sync_q <= 3'h7;
            pin_level_q <= 1'b1;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], HW_RESET_PIN_N};
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_level_q <= pin_sync_q[2];
            end
        end
    end

    // low time counted in core cycles; a low must outlast the accept point
    // the counter saturates at the accept point, so a very long low
    // cannot wrap around and look short again
    // any high sample clears it: a broken low starts over
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            low_cnt_q <= '0;
        end else if (pin_level_q) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != FILT_W'(ACCEPT_CYCLES)) begin
            low_cnt_q <= low_cnt_q + FILT_W'(1);
        end
    end

    // high time inside a held reset; short highs do not end it
    // counts only while a reset is held, so normal idle highs cost nothing
    // a low sample clears it, so a release must be one unbroken high
    // highs use the 5us reject window, lows the longer 9us accept point, so the two edges differ
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            high_cnt_q <= '0;
        end else if (!pin_level_q || !reset_req_q) begin
            high_cnt_q <= '0;
        end else if (high_cnt_q != FILT_W'(REJECT_CYCLES)) begin
            high_cnt_q <= high_cnt_q + FILT_W'(1);
        end
    end

    // filtered reset request: set after 9us low, cleared after 5us steady high
    // the 5..9us band is treated as not yet a reset, which the rules allow
    // trade-off: a late accept costs a few microseconds of response but
    // keeps long electrostatic spikes from ever starting the sequence
    // set wins over clear; both cannot be true in one cycle anyway
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            reset_req_q <= 1'b0;
        end else if (low_cnt_q == FILT_W'(ACCEPT_CYCLES)) begin
            reset_req_q <= 1'b1;
        end else if (high_cnt_q == FILT_W'(REJECT_CYCLES)) begin
            reset_req_q <= 1'b0;
        end
    end

    // sequence: blank (awake resets only), hold, reload, then wait out the recovery time
    // the blanking phase runs before hold and is not part of the
    // recovery time; recovery starts when hold sees the filtered pin high
    // a new reset during reload or wait returns to hold, never to blank,
    // because the panel is already dark by then
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            state_q <= ST_RUN;
            tmr_q <= '0;
        end else begin
            unique case (state_q)
                // normal operation; sleep level picks the blanking path
                ST_RUN: begin
                    tmr_q <= '0;
                    if (reset_req_q) begin
                        state_q <= SLEEP_IN ? ST_HOLD : ST_BLANK;
                    end
                end
                ST_BLANK: begin
                    tmr_q <= tmr_q + COUNT_W'(1);
                    // panel may finish early; cap at the longest blanking time
                    if (BLANK_DONE || tmr_q >= COUNT_W'(BLANK_MAX_CNT - 1)) begin
                        state_q <= ST_HOLD;
                    end
                end
                // defaults applied; waits for the filtered release
                ST_HOLD: begin
                    tmr_q <= '0;
                    if (!reset_req_q) begin
                        state_q <= ST_RECOVER;
                    end
                end
                // reload from the store; the timer keeps running into wait
                // so load time counts against the recovery limit
                ST_RECOVER: begin
                    tmr_q <= tmr_q + COUNT_W'(1);
                    if (reset_req_q) begin
                        state_q <= ST_HOLD;
                    end else if (loaded_q || tmr_q >= COUNT_W'(NVM_LOAD_CNT - 1)) begin
                        state_q <= ST_WAIT;
                    end
                end
                // rest of the recovery time, measured from release
                ST_WAIT: begin
                    tmr_q <= tmr_q + COUNT_W'(1);
                    if (reset_req_q) begin
                        state_q <= ST_HOLD;
                    end else if (tmr_q >= COUNT_W'(RECOVER_SLEEP_CNT - 1)) begin
                        state_q <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // settings reload; the store is trusted to answer within the load window
    // limitation: if it never answers, the old values stay and the
    // sequence moves on after the load window anyway
    // only the first valid pulse in a recovery is taken
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            loaded_q <= 1'b0;
            ID_BYTE <= 8'h00;
            COMMON_VOLTAGE_SETTING <= COMMON_VOLTAGE_SETTING_RESET;
        end else if (state_q != ST_RECOVER) begin
            loaded_q <= 1'b0;
        end else if (NVM_VALID && !loaded_q) begin
            loaded_q <= 1'b1;
            ID_BYTE <= NVM_ID;
            COMMON_VOLTAGE_SETTING <= NVM_COMMON_VOLTAGE_SETTING;
        end
    end

    // time since release, used for the host wake gate WAKE_READY only
    // held at zero while blanking or holding, so it measures from release
    // saturates at the wake limit; a core reset also restarts it
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            since_rel_q <= '0;
        end else if (state_q == ST_HOLD || state_q == ST_BLANK) begin
            since_rel_q <= '0;
        end else if (since_rel_q != COUNT_W'(RECOVER_AWAKE_CNT)) begin
            since_rel_q <= since_rel_q + COUNT_W'(1);
        end
    end

    // status outputs
    // IN_RESET, BLANK_DISPLAY, LOAD_DEFAULTS and CMD_READY come from the one-hot state alone,
    // so they change together on the edge that moves the state and never glitch apart
    assign IN_RESET = (state_q != ST_RUN);
    assign BLANK_DISPLAY = (state_q != ST_RUN);
    assign LOAD_DEFAULTS = (state_q == ST_HOLD);
    assign NVM_LOAD_REQ = (state_q == ST_RECOVER) && !loaded_q;
    // gates the host is expected to respect
    assign CMD_READY = (state_q == ST_RUN);
    // wake held off 120ms after every release, awake or not
    assign WAKE_READY = (state_q == ST_RUN) &&
        (since_rel_q == COUNT_W'(RECOVER_AWAKE_CNT));

endmodule

// [reset_seq_properties.sv]
/* reset_seq_properties: port checks for the reset sequencer.
   Assumes the bind below and small simulation counts. */
`timescale 1ns/1ps
module reset_seq_properties #(
    parameter int RECOVER_SLEEP_CNT = 50
) (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic HW_RESET_PIN_N,
    input wire logic SLEEP_IN,
    input wire logic BLANK_DONE,
    input wire logic NVM_VALID,
    input wire logic [7:0] NVM_ID,
    input wire logic [7:0] NVM_COMMON_VOLTAGE_SETTING,
    input wire logic IN_RESET,
    input wire logic BLANK_DISPLAY,
    input wire logic LOAD_DEFAULTS,
    input wire logic NVM_LOAD_REQ,
    input wire logic [7:0] ID_BYTE,
    input wire logic [7:0] COMMON_VOLTAGE_SETTING,
    input wire logic CMD_READY,
    input wire logic WAKE_READY
);
    // slack is spare margin; IN_RESET and LOAD_DEFAULTS decode state_q with no output register
    localparam int REC_MAX = RECOVER_SLEEP_CNT + 8;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    // a reset needs the pin low 200 cycles before IN_RESET rises
    a_short_low: assert property ($rose(IN_RESET) |-> !$past(HW_RESET_PIN_N, 200))
        else $error("reset taken on a short low");
    a_blank_on: assert property ($rose(IN_RESET) |-> BLANK_DISPLAY)
        else $error("display not blanked");
    a_awake_blank: assert property ($rose(IN_RESET) && !SLEEP_IN |-> !LOAD_DEFAULTS)
        else $error("awake reset skipped blanking");
    a_cmd_blocked: assert property (IN_RESET |-> !CMD_READY && !WAKE_READY)
        else $error("commands open during reset");
    a_nvm_capture: assert property (NVM_VALID && NVM_LOAD_REQ |=>
        ID_BYTE == $past(NVM_ID) && COMMON_VOLTAGE_SETTING == $past(NVM_COMMON_VOLTAGE_SETTING) && !NVM_LOAD_REQ)
        else $error("stored settings not loaded");
    a_recover_end: assert property ($fell(NVM_LOAD_REQ) && !LOAD_DEFAULTS |->
        ##[1:REC_MAX] (!IN_RESET || LOAD_DEFAULTS))
        else $error("recovery too long");
    // a release glitch cannot end the held reset at once
    a_glitch_hold: assert property ($rose(HW_RESET_PIN_N) && LOAD_DEFAULTS |-> LOAD_DEFAULTS[*8])
        else $error("held reset dropped early");
endmodule
bind display_hw_reset_sequencer reset_seq_properties #(
    .RECOVER_SLEEP_CNT(RECOVER_SLEEP_CNT)
) u_chk (.*);

// [host_model.sv]
/* host_model: host side of the reset pin.
   Assumes the caller waits for CMD_READY and WAKE_READY. */
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic pin_n
);
    initial pin_n = 1'b1;
    // pin level held for n cycles; lows set the pulse length
    task drive(input logic v, input int n);
        @(posedge clk);
        pin_n <= v;
        repeat (n) @(posedge clk);
    endtask
    // no command traffic is modelled, so wait rules hold trivially
endmodule

// [testbench.sv]
/* testbench: pulse table then glitch and reset cases.
   Assumes the sim-sized counts set on u_dut. */
`timescale 1ns/1ps
module testbench;
    logic clk = 0, srst = 1, slp = 0, nvld = 0, seen = 0, bdone = 0;
    logic [7:0] nid = 8'h00;
    wire pin_n, in_rst, ld_req, cmd_rdy, wake_rdy, blank, ld_def;
    wire [7:0] id_b, common_voltage_setting;
    int fail_count = 0, compares = 0, cyc = 0;
    // rows: low length, sleep, reset expected
    int rows [4][3] = '{'{150, 1, 0}, '{200, 0, 0}, '{380, 1, 1}, '{380, 0, 1}};
    host_model hm (.clk(clk), .pin_n(pin_n));
    display_hw_reset_sequencer #(.RECOVER_SLEEP_CNT(50), .RECOVER_AWAKE_CNT(120),
        .NVM_LOAD_CNT(20), .BLANK_MAX_CNT(40)) u_dut (.CORE_CLK(clk), .SRST(srst),
        .HW_RESET_PIN_N(pin_n), .SLEEP_IN(slp), .BLANK_DONE(bdone), .NVM_VALID(nvld),
        .NVM_ID(nid), .NVM_COMMON_VOLTAGE_SETTING(~nid), .IN_RESET(in_rst), .BLANK_DISPLAY(blank),
        .LOAD_DEFAULTS(ld_def), .NVM_LOAD_REQ(ld_req), .ID_BYTE(id_b),
        .COMMON_VOLTAGE_SETTING(common_voltage_setting), .CMD_READY(cmd_rdy), .WAKE_READY(wake_rdy));
    initial forever #12.5 clk = ~clk;
    // store answers one cycle after a request; seen latches any reset
    always @(posedge clk) begin
        nvld <= ld_req && !nvld;
        if (in_rst === 1'b1) seen <= 1'b1;
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task chk(input logic [7:0] a, input logic [7:0] b);
        compares++;
        if (a !== b) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, a, b);
        end
    endtask
    task report_and_stop();
        $display("errors %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(id_b, 8'h00);
        for (int i = 0; i < 4; i++) begin
            slp <= rows[i][1][0];
            nid <= 8'h21 + i[7:0];
            seen <= 1'b0;
            hm.drive(1'b0, rows[i][0]);
            hm.drive(1'b1, 1000);
            chk(seen, rows[i][2][0]);
            chk(in_rst, 1'b0);
            chk(cmd_rdy, 1'b1);
            chk(wake_rdy, 1'b1);
            if (rows[i][2] == 1) chk(common_voltage_setting, ~(8'h21 + i[7:0]));
        end
        // a short high inside a held reset must not start recovery
        nid <= 8'h5a;
        hm.drive(1'b0, 380);
        hm.drive(1'b1, 100);
        hm.drive(1'b0, 100);
        chk(in_rst, 1'b1);
        chk(ld_req, 1'b0);
        hm.drive(1'b1, 1000);
        chk(id_b, 8'h5a);
        // awake reset with early blanking done spends one cycle in blank, then goes to hold
        bdone <= 1'b1;
        hm.drive(1'b0, 380);
        chk(ld_def, 1'b1);
        chk(blank, 1'b1);
        chk(cmd_rdy, 1'b0);
        bdone <= 1'b0;
        // sync reset in mid-sequence returns to idle
        hm.drive(1'b0, 400);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(in_rst, 1'b0);
        chk(cmd_rdy, 1'b1);
        chk(wake_rdy, 1'b0);
        report_and_stop();
    end
endmodule
